/* shared/irq_pkg.sv */
package irq_pkg;
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int NSRC = 5;

    // Register byte offsets
    localparam logic [7:0] A_CTRL   = 8'h00;
    localparam logic [7:0] A_PRIO   = 8'h04;
    localparam logic [7:0] A_MODE   = 8'h08;
    localparam logic [7:0] A_EVENT  = 8'h0C;
    localparam logic [7:0] A_VECTOR = 8'h10;
    localparam logic [7:0] A_STATUS = 8'h14;
    localparam logic [7:0] A_EOI    = 8'h18;

    // Field positions
    localparam int CTRL_IEN    = 5;
    localparam int MODE_CAS_A  = 0;
    localparam int MODE_CAS_B  = 1;
    localparam int MODE_NEST   = 2;
    localparam int MODE_TRIG   = 3;
    localparam int MODE_SSF    = 8;
    localparam int MODE_OVF    = 9;
    localparam int PRIO_PMASK  = 15;
    localparam int VEC_DONE    = 31;
    localparam int EV_DIV      = 0;
    localparam int EV_INSTR    = 1;
    localparam int EV_EXEMPT   = 2;
    localparam int EV_BREAK    = 3;
    localparam int EV_INTO     = 4;
    localparam int EV_BOUND    = 5;
    localparam int EV_UNDEF    = 6;
    localparam int EV_ESCAPE   = 7;
    localparam int EV_PREFIX   = 8;
    localparam int VEC_SHIFT   = 2;

    // Interrupt types
    localparam logic [7:0] T_DIVIDE   = 8'h00;
    localparam logic [7:0] T_TRACE    = 8'h01;
    localparam logic [7:0] T_NMI      = 8'h02;
    localparam logic [7:0] T_BREAK    = 8'h03;
    localparam logic [7:0] T_OVERFLOW = 8'h04;
    localparam logic [7:0] T_BOUNDS   = 8'h05;
    localparam logic [7:0] T_UNUSED   = 8'h06;
    localparam logic [7:0] T_ESCAPE   = 8'h07;
    localparam logic [7:0] T_EXT_BASE = 8'h0C;

    // Values after reset
    localparam logic [14:0] PRIO_RESET  = 15'h7FFF;
    localparam logic [2:0]  PMASK_RESET = 3'h7;
    localparam logic [4:0]  MASK_RESET  = 5'h1F;
    localparam logic [3:0]  ISR_NONE    = 4'h8;
    localparam logic [14:0] DEV_SYNC_INIT  = 15'h7FE0;
    localparam logic [2:0]  PART_SYNC_INIT = 3'h3;

    typedef enum logic [8:0] {
        S_IDLE = 9'h001,
        S_SAVE = 9'h002,
        S_ACK1 = 9'h004,
        S_W1   = 9'h008,
        S_GAP1 = 9'h010,
        S_GAP2 = 9'h020,
        S_ACK2 = 9'h040,
        S_W2   = 9'h080,
        S_FIN  = 9'h100
    } take_state_t;
endpackage

/* shared/irq_link_if.sv */
`timescale 1ns/1ps
interface irq_link_if;
    logic       external_request_a;
    logic       external_request_b;
    logic       external_request_c;
    logic       external_request_d;
    logic       external_request_e;
    logic       nmi_request;
    logic       acknowledge_out_a_n;
    logic       acknowledge_out_b_n;
    logic       address_latch;
    logic       read_strobe_n;
    logic       ready;
    logic [7:0] bus_out;
    logic       bus_oe;
    logic [7:0] low_muxed_bus_lines;

    // Undriven bus floats high
    assign low_muxed_bus_lines = bus_oe ? bus_out : 8'hFF;

    modport device (
        input  external_request_a, external_request_b, external_request_c,
        input  external_request_d, external_request_e, nmi_request, ready, low_muxed_bus_lines,
        output acknowledge_out_a_n, acknowledge_out_b_n, address_latch, read_strobe_n
    );
    modport partner (
        output external_request_a, external_request_b, external_request_c,
        output external_request_d, external_request_e, nmi_request, ready, bus_out, bus_oe,
        input  acknowledge_out_a_n, acknowledge_out_b_n, address_latch, read_strobe_n
    );
endinterface

/* src/pin_sync.sv */
`timescale 1ns/1ps
module pin_sync #(
    parameter int           W    = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input  wire logic         core_clk_i,
    input  wire logic         reset_n_i,
    input  wire logic [W-1:0] pin_i,
    output logic      [W-1:0] level_o
);
    typedef struct packed {
        logic [W-1:0] f1;
        logic [W-1:0] f2;
        logic [W-1:0] f3;
        logic [W-1:0] lvl;
    } sync_t;

    sync_t s;
    sync_t next_s;

    always_comb begin
        next_s = s;
        next_s.f1 = pin_i;
        next_s.f2 = s.f1;
        next_s.f3 = s.f2;
        // Change accepted once stages two and three agree
        next_s.lvl = (s.f2 & s.f3) | (s.lvl & (s.f2 ^ s.f3));
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s <= {INIT, INIT, INIT, INIT};
        end else begin
            s <= next_s;
        end
    end

    assign level_o = s.lvl;
endmodule // pin_sync

/* src/irq_device.sv */
`timescale 1ns/1ps
// How it works
// - Exception types rank above all maskable requests
// - Trace first, then NMI, then other exceptions
// - Maskable: programmed level first, fixed order ties
// - Levels zero to seven, zero most urgent
// - Division overflow raises type 00h
// - Single-step raises 01h after non-exempt instructions
// - Single-step flag cleared after flags saved, on trace takes only
// - NMI on rising edge only, type 02h
// - NMI has no request or service bit
// - Taking hardware interrupt clears interrupt enable
// - Breakpoint opcode raises type 03h
// - Overflow trap only when overflow flag set
// - Bounds failure raises type 05h
// - Undefined opcode raises type 06h
// - Escape always traps 07h, return at prefix
// - Internal type: no acknowledge cycles
// - External type read on second acknowledge
// - Locked, two idle gaps, waits on ready
// - Latch strobe once per acknowledge, read strobe idle
// - Software ranks cascaded pins above others
// - Reset: modes cleared, levels lowest, all masked
// - Reset: service, request cleared, priority mask seven
// - Table index is type shifted left two
module irq_device (
    input  wire logic        core_clk_i,
    input  wire logic        reset_n_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    output logic             bus_locked_o,
    output logic             taken_o,
    output logic      [9:0]  vector_index_o,
    irq_link_if.device       link
);
    typedef struct packed {
        irq_pkg::take_state_t st;
        logic [4:0]  source_mask_bit;
        logic        ien;
        logic [14:0] prio;
        logic [2:0]  pmask;
        logic        cas_a;
        logic        cas_b;
        logic        special_nesting_bit;
        logic [4:0]  level_trigger_bit;
        logic        ssf;
        logic        ovf;
        logic [4:0]  req;
        logic [4:0]  isr;
        logic [4:0]  last;
        logic        nmi_last;
        logic        trace_pend;
        logic        nmi_pend;
        logic        exc_pend;
        logic [7:0]  exc_type;
        logic        exc_prefix;
        logic        at_prefix;
        logic [7:0]  cur_type;
        logic [2:0]  cur_src;
        logic        cur_hw;
        logic        cur_ext;
        logic        cur_trace;
        logic [2:0]  saved;
        logic [7:0]  vtype;
        logic [9:0]  vindex;
        logic        vdone;
        logic        taken;
        logic [31:0] rdata;
    } dev_t;

    dev_t        s;
    dev_t        next_s;
    logic [14:0] pins;

    pin_sync #(.W(15), .INIT(irq_pkg::DEV_SYNC_INIT)) u_sync (
        .core_clk_i (core_clk_i),
        .reset_n_i  (reset_n_i),
        .pin_i      ({link.low_muxed_bus_lines, link.ready, link.nmi_request, link.external_request_e,
                      link.external_request_d, link.external_request_c, link.external_request_b,
                      link.external_request_a}),
        .level_o    (pins)
    );

    always_comb begin
        logic [3:0]  isr_lvl;
        logic [2:0]  lvl;
        logic [2:0]  best;
        logic [2:0]  win;
        logic        found;
        logic        wr;
        logic [4:0]  rise;
        logic [4:0]  req_set;
        logic [4:0]  req_clr;
        logic [4:0]  isr_set;
        logic [4:0]  isr_clr;
        logic [31:0] rd;
        isr_lvl = irq_pkg::ISR_NONE;
        lvl = 3'h0;
        best = 3'h7;
        win = 3'h0;
        found = 1'b0;
        wr = psel_i && penable_i && pwrite_i;
        rise = pins[4:0] & ~s.last;
        req_set = '0;
        req_clr = '0;
        isr_set = '0;
        isr_clr = '0;
        rd = '0;
        next_s = s;
        next_s.taken = 1'b0;
        next_s.last = pins[4:0];
        next_s.nmi_last = pins[5];

        // Lowest level currently in service
        for (int i = 0; i < irq_pkg::NSRC; i++) begin
            lvl = s.prio[3*i +: 3];
            if (s.isr[i] && {1'b0, lvl} < isr_lvl) begin
                isr_lvl = {1'b0, lvl};
            end
        end
        for (int i = 0; i < irq_pkg::NSRC; i++) begin
            lvl = s.prio[3*i +: 3];
            if (s.req[i] && !s.source_mask_bit[i] && lvl <= s.pmask
                    && ({1'b0, lvl} < isr_lvl
                        || ({1'b0, lvl} == isr_lvl && (!s.isr[i] || s.special_nesting_bit)))) begin
                if (!found || lvl < best) begin
                    found = 1'b1;
                    best = lvl;
                    win = 3'(i);
                end
            end
        end

        for (int i = 0; i < irq_pkg::NSRC; i++) begin
            if (s.level_trigger_bit[i]) begin
                req_set[i] = pins[i];
                req_clr[i] = ~pins[i];
            end else begin
                req_set[i] = rise[i];
            end
        end

        case (s.st)
            irq_pkg::S_IDLE: begin
                next_s.cur_trace = 1'b0;
                next_s.cur_hw = 1'b0;
                next_s.cur_ext = 1'b0;
                if (s.trace_pend) begin
                    next_s.trace_pend = 1'b0;
                    next_s.cur_type = irq_pkg::T_TRACE;
                    next_s.cur_trace = 1'b1;
                    next_s.st = irq_pkg::S_SAVE;
                end else if (s.nmi_pend) begin
                    next_s.nmi_pend = 1'b0;
                    next_s.cur_type = irq_pkg::T_NMI;
                    next_s.cur_hw = 1'b1;
                    next_s.st = irq_pkg::S_SAVE;
                end else if (s.exc_pend) begin
                    next_s.exc_pend = 1'b0;
                    next_s.cur_type = s.exc_type;
                    next_s.at_prefix = s.exc_prefix;
                    next_s.st = irq_pkg::S_SAVE;
                end else if (found && s.ien) begin
                    req_clr[win] = ~s.level_trigger_bit[win];
                    isr_set[win] = 1'b1;
                    next_s.cur_src = win;
                    next_s.cur_type = irq_pkg::T_EXT_BASE + 8'(win);
                    next_s.cur_hw = 1'b1;
                    next_s.cur_ext = (win == 3'h0 && s.cas_a) || (win == 3'h1 && s.cas_b);
                    next_s.st = irq_pkg::S_SAVE;
                end
            end
            irq_pkg::S_SAVE: begin
                next_s.saved = {s.ssf, s.ovf, s.ien};
                if (s.cur_trace) begin
                    next_s.ssf = 1'b0;
                end
                if (s.cur_hw) begin
                    next_s.ien = 1'b0;
                end
                next_s.st = s.cur_ext ? irq_pkg::S_ACK1 : irq_pkg::S_FIN;
            end
            irq_pkg::S_ACK1: next_s.st = irq_pkg::S_W1;
            irq_pkg::S_W1: begin
                if (pins[6]) begin
                    next_s.st = irq_pkg::S_GAP1;
                end
            end
            irq_pkg::S_GAP1: next_s.st = irq_pkg::S_GAP2;
            irq_pkg::S_GAP2: next_s.st = irq_pkg::S_ACK2;
            irq_pkg::S_ACK2: next_s.st = irq_pkg::S_W2;
            irq_pkg::S_W2: begin
                if (pins[6]) begin
                    next_s.cur_type = pins[14:7];
                    next_s.st = irq_pkg::S_FIN;
                end
            end
            irq_pkg::S_FIN: begin
                next_s.vtype = s.cur_type;
                next_s.vindex = {s.cur_type, 2'b00};
                next_s.taken = 1'b1;
                next_s.st = irq_pkg::S_IDLE;
            end
            default: next_s.st = irq_pkg::S_IDLE;
        endcase

        // New edge wins over a take in the same cycle
        if (pins[5] && !s.nmi_last) begin
            next_s.nmi_pend = 1'b1;
        end

        case (paddr_i)
            irq_pkg::A_CTRL:   rd = {26'h0, s.ien, s.source_mask_bit};
            irq_pkg::A_PRIO:   rd = {14'h0, s.pmask, s.prio};
            irq_pkg::A_MODE:   rd = {22'h0, s.ovf, s.ssf, s.level_trigger_bit, s.special_nesting_bit, s.cas_b, s.cas_a};
            irq_pkg::A_VECTOR: rd = {s.vdone, 9'h0, s.saved, s.at_prefix, s.vindex, s.vtype};
            irq_pkg::A_STATUS: rd = {20'h0, bus_locked_o, s.st != irq_pkg::S_IDLE, s.isr, s.req};
            default:           rd = '0;
        endcase
        if (psel_i && !penable_i) begin
            next_s.rdata = rd;
        end

        if (wr) begin
            case (paddr_i)
                irq_pkg::A_CTRL: begin
                    next_s.source_mask_bit = pwdata_i[4:0];
                    next_s.ien = pwdata_i[irq_pkg::CTRL_IEN];
                end
                irq_pkg::A_PRIO: begin
                    next_s.prio = pwdata_i[14:0];
                    next_s.pmask = pwdata_i[irq_pkg::PRIO_PMASK +: 3];
                end
                irq_pkg::A_MODE: begin
                    next_s.cas_a = pwdata_i[irq_pkg::MODE_CAS_A];
                    next_s.cas_b = pwdata_i[irq_pkg::MODE_CAS_B];
                    next_s.special_nesting_bit = pwdata_i[irq_pkg::MODE_NEST];
                    next_s.level_trigger_bit = pwdata_i[irq_pkg::MODE_TRIG +: 5];
                    next_s.ssf = pwdata_i[irq_pkg::MODE_SSF];
                    next_s.ovf = pwdata_i[irq_pkg::MODE_OVF];
                end
                irq_pkg::A_EVENT: begin
                    next_s.exc_prefix = 1'b0;
                    next_s.exc_pend = 1'b1;
                    if (pwdata_i[irq_pkg::EV_DIV]) begin
                        next_s.exc_type = irq_pkg::T_DIVIDE;
                    end else if (pwdata_i[irq_pkg::EV_BREAK]) begin
                        next_s.exc_type = irq_pkg::T_BREAK;
                    end else if (pwdata_i[irq_pkg::EV_INTO] && s.ovf) begin
                        next_s.exc_type = irq_pkg::T_OVERFLOW;
                    end else if (pwdata_i[irq_pkg::EV_BOUND]) begin
                        next_s.exc_type = irq_pkg::T_BOUNDS;
                    end else if (pwdata_i[irq_pkg::EV_UNDEF]) begin
                        next_s.exc_type = irq_pkg::T_UNUSED;
                    end else if (pwdata_i[irq_pkg::EV_ESCAPE]) begin
                        next_s.exc_type = irq_pkg::T_ESCAPE;
                        next_s.exc_prefix = pwdata_i[irq_pkg::EV_PREFIX];
                    end else begin
                        // Keep a pending exception unless idle takes it now
                        next_s.exc_pend = s.exc_pend && !(s.st == irq_pkg::S_IDLE && !s.trace_pend && !s.nmi_pend);
                        next_s.exc_prefix = s.exc_prefix;
                    end
                    if (s.ssf && pwdata_i[irq_pkg::EV_INSTR] && !pwdata_i[irq_pkg::EV_EXEMPT]) begin
                        next_s.trace_pend = 1'b1;
                    end
                end
                irq_pkg::A_VECTOR: begin
                    if (pwdata_i[irq_pkg::VEC_DONE]) begin
                        next_s.vdone = 1'b0;
                    end
                end
                irq_pkg::A_EOI: isr_clr = pwdata_i[4:0];
                default: ;
            endcase
        end

        // Hardware set wins over clear
        next_s.req = (s.req & ~req_clr) | req_set;
        next_s.isr = (s.isr & ~isr_clr) | isr_set;
        if (s.st == irq_pkg::S_FIN) begin
            next_s.vdone = 1'b1;
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s <= '0;
            s.st <= irq_pkg::S_IDLE;
            s.prio <= irq_pkg::PRIO_RESET;
            s.source_mask_bit <= irq_pkg::MASK_RESET;
            s.pmask <= irq_pkg::PMASK_RESET;
            s.nmi_last <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign prdata_o = s.rdata;
    assign pready_o = 1'b1;
    assign pslverr_o = psel_i && penable_i && (paddr_i[1:0] != 2'b00 || paddr_i > irq_pkg::A_EOI);
    assign bus_locked_o = s.st inside {irq_pkg::S_ACK1, irq_pkg::S_W1, irq_pkg::S_GAP1, irq_pkg::S_GAP2,
                                       irq_pkg::S_ACK2, irq_pkg::S_W2};
    assign taken_o = s.taken;
    assign vector_index_o = s.vindex;
    assign link.address_latch = s.st == irq_pkg::S_ACK1 || s.st == irq_pkg::S_ACK2;
    assign link.read_strobe_n = 1'b1;
    assign link.acknowledge_out_a_n = !(s.cur_src == 3'h0 && s.st inside {irq_pkg::S_ACK1, irq_pkg::S_W1,
                                        irq_pkg::S_ACK2, irq_pkg::S_W2});
    assign link.acknowledge_out_b_n = !(s.cur_src == 3'h1 && s.st inside {irq_pkg::S_ACK1, irq_pkg::S_W1,
                                        irq_pkg::S_ACK2, irq_pkg::S_W2});
endmodule // irq_device

/* src/irq_partner.sv */
`timescale 1ns/1ps
module irq_partner (
    input  wire logic       core_clk_i,
    input  wire logic       reset_n_i,
    input  wire logic [4:0] raise_i,
    input  wire logic       nmi_i,
    input  wire logic [7:0] type_a_i,
    input  wire logic [7:0] type_b_i,
    input  wire logic       hold_ready_i,
    output logic            type_sent_o,
    irq_link_if.partner     link
);
    typedef struct packed {
        logic [4:0] req;
        logic       nmi;
        logic       ready;
        logic       ready_owed;
        logic       ack_last;
        logic       second;
        logic       oe;
        logic [7:0] data;
        logic       sent;
    } part_t;

    part_t      s;
    part_t      next_s;
    logic [2:0] pins;

    pin_sync #(.W(3), .INIT(irq_pkg::PART_SYNC_INIT)) u_sync (
        .core_clk_i (core_clk_i),
        .reset_n_i  (reset_n_i),
        .pin_i      ({link.address_latch, link.acknowledge_out_b_n, link.acknowledge_out_a_n}),
        .level_o    (pins)
    );

    always_comb begin
        logic ack;
        ack = !(pins[0] && pins[1]);
        next_s = s;
        next_s.sent = 1'b0;
        next_s.req = raise_i;
        next_s.nmi = nmi_i;
        next_s.ready = 1'b0;
        next_s.ack_last = ack;
        // Two-cycle ready pulse passes the synchroniser and is gone before the next wait
        if (s.ready_owed && !hold_ready_i) begin
            next_s.ready = 1'b1;
            next_s.ready_owed = !s.ready;
        end
        if (ack && !s.ack_last) begin
            next_s.ready_owed = 1'b1;
            if (s.second) begin
                // Type only during the second acknowledge
                next_s.oe = 1'b1;
                next_s.data = !pins[0] ? type_a_i : type_b_i;
                next_s.second = 1'b0;
                next_s.sent = 1'b1;
            end else begin
                next_s.second = 1'b1;
            end
        end else if (!ack) begin
            next_s.oe = 1'b0;
            next_s.ready_owed = 1'b0;
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign type_sent_o = s.sent;
    assign link.external_request_a = s.req[0];
    assign link.external_request_b = s.req[1];
    assign link.external_request_c = s.req[2];
    assign link.external_request_d = s.req[3];
    assign link.external_request_e = s.req[4];
    assign link.nmi_request = s.nmi;
    assign link.ready = s.ready;
    assign link.bus_out = s.data;
    assign link.bus_oe = s.oe;
endmodule // irq_partner

/* verif/irq_chk.sv */
`timescale 1ns/1ps
module irq_chk (
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input wire logic acknowledge_out_a_n,
    input wire logic acknowledge_out_b_n,
    input wire logic address_latch,
    input wire logic read_strobe_n,
    input wire logic nmi_request
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);

    a_read_strobe_idle: assert property (read_strobe_n)
        else $error("read strobe active");
    a_latch_one_cycle: assert property (address_latch |=> !address_latch)
        else $error("latch strobe longer than one cycle");
    a_latch_needs_ack: assert property (address_latch |-> !acknowledge_out_a_n || !acknowledge_out_b_n)
        else $error("latch strobe outside acknowledge");
    a_acks_exclusive: assert property (acknowledge_out_a_n || acknowledge_out_b_n)
        else $error("both acknowledges low");
    a_ack_a_latch: assert property ($fell(acknowledge_out_a_n) |-> address_latch)
        else $error("acknowledge a without latch strobe");
    a_ack_b_latch: assert property ($fell(acknowledge_out_b_n) |-> address_latch)
        else $error("acknowledge b without latch strobe");
    a_gap_idle_a: assert property ($rose(acknowledge_out_a_n) |-> acknowledge_out_a_n[*2])
        else $error("gap after acknowledge a too short");
    a_gap_idle_b: assert property ($rose(acknowledge_out_b_n) |-> acknowledge_out_b_n[*2])
        else $error("gap after acknowledge b too short");
    a_ack_a_ends: assert property ($fell(acknowledge_out_a_n) |-> ##[1:100] $rose(acknowledge_out_a_n))
        else $error("acknowledge a never ends");

    c_ack_a: cover property ($fell(acknowledge_out_a_n));
    c_ack_b: cover property ($fell(acknowledge_out_b_n));
    c_nmi: cover property ($rose(nmi_request));
endmodule // irq_chk

/* verif/tb_irq_device.sv */
`timescale 1ns/1ps
module tb_interrupt_priority_acknowledge;
    logic        core_clk_i = 0, reset_n_i = 0, psel = 0, penable = 0, pwrite = 0, pslverr, pready, locked, taken;
    logic        nmi = 1, hold = 0, sent;
    logic [4:0]  raise = 0;
    logic [7:0]  paddr = 0, ta = 0, tb = 0;
    logic [31:0] pwdata = 0, prdata, r;
    logic [9:0]  vidx;
    logic [9:0]  got[$];
    int          fail_count = 0, compares = 0, seed = 43, lv[5], acks = 0, i, it, w, seen_lock = 0, sends = 0;
    logic [4:0]  pend;
    logic [31:0] prio;

    irq_link_if link();
    irq_device u_irq_device (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .bus_locked_o(locked), .taken_o(taken), .vector_index_o(vidx), .link(link));
    irq_partner u_irq_partner (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .raise_i(raise), .nmi_i(nmi),
        .type_a_i(ta), .type_b_i(tb), .hold_ready_i(hold), .type_sent_o(sent), .link(link));
    irq_chk u_chk (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .acknowledge_out_a_n(link.acknowledge_out_a_n),
        .acknowledge_out_b_n(link.acknowledge_out_b_n), .address_latch(link.address_latch),
        .read_strobe_n(link.read_strobe_n), .nmi_request(link.nmi_request));

    always #10 core_clk_i = ~core_clk_i;
    always @(posedge core_clk_i) begin
        if (taken === 1'b1) got.push_back(vidx);
        if (locked === 1'b1) seen_lock = 1;
        if (sent === 1'b1) sends++;
    end
    always @(negedge link.acknowledge_out_a_n or negedge link.acknowledge_out_b_n) acks++;

    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge core_clk_i);
        penable <= 1;
        do @(posedge core_clk_i); while (pready !== 1'b1);
        r = prdata;
        chk("slave error", {31'h0, pslverr}, {31'h0, a > 8'h18 || a[1:0] != 2'b00});
        psel <= 0; penable <= 0;
    endtask
    task automatic rd(input string n, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(0, a, 0);
        chk(n, r & m, e);
    endtask
    task automatic expect_type(input logic [7:0] t);
        int n;
        n = 0;
        while (got.size() == 0 && n < 300) begin
            @(posedge core_clk_i);
            n++;
        end
        chk("vector index", (got.size() > 0) ? {22'h0, got.pop_front()} : 32'hFFFF_FFFF, {22'h0, t, 2'b00});
    endtask
    task automatic no_take(input int n);
        repeat (n) @(posedge core_clk_i);
        chk("takes", got.size(), 0);
    endtask
    function automatic int winner(input logic [4:0] p);
        int b;
        b = -1;
        for (int k = 0; k < 5; k++) if (p[k] && (b < 0 || lv[k] < lv[b])) b = k;
        return b;
    endfunction
    task automatic casc(input logic [31:0] mode, input logic [4:0] pin, input logic [7:0] t, input int ext);
        int a0;
        int s0;
        apb(1, irq_pkg::A_MODE, mode);
        apb(1, irq_pkg::A_PRIO, mode[0] ? 32'h39248 : 32'h39241);
        a0 = acks;
        s0 = sends;
        hold <= 1;
        raise <= pin;
        apb(1, irq_pkg::A_CTRL, 32'h20);
        repeat (20) @(posedge core_clk_i);
        hold <= 0;
        expect_type(t);
        chk("acknowledge falls", acks - a0, ext ? 2 : 0);
        chk("type sent", sends - s0, ext);
        raise <= 0;
        apb(1, irq_pkg::A_EOI, 32'h1F);
    endtask
    task automatic summarize;
        if (fail_count == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    initial begin
        #1_000_000;
        fail_count++;
        summarize;
    end

    initial begin
        repeat (4) @(posedge core_clk_i);
        reset_n_i <= 1;
        rd("priority", irq_pkg::A_PRIO, 32'hFFFF_FFFF, 32'h3FFFF);
        rd("control", irq_pkg::A_CTRL, 32'hFFFF_FFFF, 32'h1F);
        rd("mode", irq_pkg::A_MODE, 32'hFFFF_FFFF, 0);
        rd("status", irq_pkg::A_STATUS, 32'hFFFF_FFFF, 0);
        rd("unmapped", 8'h1C, 32'hFFFF_FFFF, 0);
        no_take(20);
        nmi <= 0;
        apb(1, irq_pkg::A_EVENT, 32'h10);
        no_take(20);
        apb(1, irq_pkg::A_MODE, 32'h200);
        for (i = 0; i < 8; i++) if (i != 1 && i != 2) begin
            apb(1, irq_pkg::A_EVENT, 32'h1 << i);
            expect_type(i);
        end
        apb(1, irq_pkg::A_EVENT, 32'h180);
        expect_type(7);
        rd("prefix return", irq_pkg::A_VECTOR, 32'h40000, 32'h40000);
        apb(1, irq_pkg::A_MODE, 32'h100);
        apb(1, irq_pkg::A_EVENT, 32'h6);
        no_take(20);
        apb(1, irq_pkg::A_EVENT, 32'h3);
        expect_type(1);
        expect_type(0);
        rd("step flag", irq_pkg::A_MODE, 32'h100, 0);
        apb(1, irq_pkg::A_CTRL, 32'h3F);
        nmi <= 1;
        expect_type(2);
        rd("enable after nmi", irq_pkg::A_CTRL, 32'h3F, 32'h1F);
        nmi <= 0;
        for (it = 0; it < 4; it++) begin
            prio = 32'h38000;
            for (i = 0; i < 5; i++) begin
                lv[i] = $unsigned($random(seed)) % 8;
                prio = prio | (lv[i] << (3 * i));
            end
            pend = $unsigned($random(seed)) % 31 + 1;
            apb(1, irq_pkg::A_PRIO, prio);
            raise <= pend;
            repeat (8) @(posedge core_clk_i);
            raise <= 0;
            if (it == 0) apb(1, irq_pkg::A_EVENT, 32'h1);
            while (pend != 0) begin
                apb(1, irq_pkg::A_CTRL, 32'h20);
                if (it == 0) expect_type(0);
                it = (it == 0) ? 4 : it;
                w = winner(pend);
                expect_type(irq_pkg::T_EXT_BASE + w[7:0]);
                rd("enable after take", irq_pkg::A_CTRL, 32'h20, 0);
                pend[w] = 0;
                apb(1, irq_pkg::A_EOI, 32'h1F);
            end
            it = (it == 4) ? 0 : it;
        end
        apb(1, irq_pkg::A_PRIO, 32'h38000);
        ta <= $random(seed);
        tb <= $random(seed);
        @(posedge core_clk_i);
        casc(32'h1, 5'h01, ta, 1);
        casc(32'h2, 5'h02, tb, 1);
        casc(32'h1, 5'h04, 8'h0E, 0);
        chk("bus locked", seen_lock, 1);
        summarize;
    end
endmodule // tb_interrupt_priority_acknowledge
